// *** hdl/emb_pkg.sv ***
// Constants, control layout and types of the embedded memory block.
// Assumes a 32-bit APB register bus and a single clock domain.
`default_nettype none
package emb_pkg;
  localparam int unsigned ENTRIES = 32;
  localparam int unsigned WIDTH   = 32;
  localparam int unsigned LINES   = 16;
  localparam int unsigned AW      = 5;
  localparam int unsigned PAW     = 8;
  localparam int unsigned SPLIT_W = 8;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_WMASK  = 8'h0C;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_KEY    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1C;

  localparam int unsigned CMD_WRITE_BIT = 0;
  localparam int unsigned CMD_READ_BIT  = 1;
  localparam int unsigned CMD_MASK_BIT  = 2;
  localparam int unsigned STAT_BUSY_BIT  = 9;
  localparam int unsigned STAT_MATCH_BIT = 8;
  localparam int unsigned BANK_BIT       = 31;

  localparam logic [31:0] CARE_ALL  = 32'hFFFF_FFFF;
  localparam logic [31:0] CARE_UNEN = 32'h7FFF_FFFF;
  localparam logic [13:0] CTRL_RESET = 14'h0000;

  typedef enum logic [1:0] {
    FN_OFF = 2'h0,
    FN_RAM = 2'h1,
    FN_CAM = 2'h2,
    FN_ROM = 2'h3
  } emb_func_t;

  typedef enum logic [1:0] {
    CM_SINGLE = 2'h0,
    CM_MULTI  = 2'h1,
    CM_FAST   = 2'h2,
    CM_RSVD   = 2'h3
  } emb_cmode_t;

  // Bits [13:8] select optional stages: din, dout, raddr, waddr, write, fetch
  typedef struct packed {
    logic [5:0] regs;
    logic       clr;
    logic       split;
    logic       lowpwr;
    logic       unenc;
    emb_cmode_t cmode;
    emb_func_t  func;
  } emb_ctrl_t;

  typedef struct packed {
    logic              wr;
    logic              mask;
    logic              fetch_strobe;
    logic [AW-1:0]     waddr;
    logic [AW-1:0]     raddr;
    logic [WIDTH-1:0]  data;
    logic [WIDTH-1:0]  dcm;
  } emb_req_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SLOW  = 7'h02,
    ST_WR1   = 7'h04,
    ST_WR2   = 7'h08,
    ST_WR3   = 7'h10,
    ST_LOOK  = 7'h20,
    ST_LOOK2 = 7'h40
  } emb_state_t;
endpackage : emb_pkg
`default_nettype wire

// *** hdl/emb_memory_block.sv ***
// Embedded memory block: single-port RAM, content search memory and ROM.
// Assumes an APB master on CLK; RST and GLOBAL_CLR are asynchronous clears.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: Block hosts up to two single-port RAMs
// R2: All registers clear from local, global, reset
// R3: Search key returns matching entry address
// R4: Parallel compare; match flag high on hit
// R5: Search memory holds 32 words of 32 bits
// R6: Don't-care stored bits never block matches
// R7: Single, multiple, fast modes; encoded or unencoded
// R8: Encoded output gives binary index of hit
// R9: Unencoded output uses 16 one-hot lines
// R10: Unencoded keys use 31 bits plus bank
// R11: Bank one odd entries, zero even entries
// R12: Single mode: write two cycles, lookup one
// R13: Duplicated data uses multiple-match modes
// R14: Multiple mode reports 32 entries over two cycles
// R15: Fabric priority-encodes multiple-match lines
// R16: Fast mode one cycle, sixteen entries only
// R17: Preload at configuration; writes two, masked three
// R18: Independent optional input and output stages
// R19: Separate input and output clocking allowed; here input and output stages both run on CLK
// R20: ROM holds configuration pattern as lookup table
// R21: Per-block low power adds access delay
// R22: Unused block held fully powered down
// R23: Write data, address, request are registered
// R24: Write pulse generated internally from clock
// R25: Split halves identical, at most eight wide
// R26: Match flag low on missed lookup
module emb_memory_block #(
  parameter logic [emb_pkg::ENTRIES*emb_pkg::WIDTH-1:0] INIT_IMAGE = '0
) (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic                      GLOBAL_CLR,
  input  wire logic                      LOCAL_CLR,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [emb_pkg::PAW-1:0]   PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  output logic                           MATCH,
  output logic                           POWER_DOWN
);
  logic                            arst;
  emb_pkg::emb_ctrl_t              ctrl;
  logic [emb_pkg::AW-1:0]          addr_reg;
  logic [31:0]                     wdata;
  logic [31:0]                     wmask;
  logic [31:0]                     key;
  emb_pkg::emb_req_t               req_in;
  emb_pkg::emb_req_t               req_q;
  emb_pkg::emb_req_t               req_eff;
  emb_pkg::emb_req_t               op;
  emb_pkg::emb_state_t             state;
  logic [emb_pkg::WIDTH-1:0]       mem_data [emb_pkg::ENTRIES];
  logic [emb_pkg::WIDTH-1:0]       mem_dc   [emb_pkg::ENTRIES];
  logic [emb_pkg::ENTRIES-1:0]     hit_vec;
  logic [emb_pkg::LINES-1:0]       bank_lines;
  logic [31:0]                     care;
  logic                            scope_hit;
  logic [emb_pkg::AW-1:0]          index;
  logic [31:0]                     result;
  logic [31:0]                     result_q;
  logic                            busy;
  logic                            unmapped;
  logic                            setup;
  logic                            wr_acc;
  logic                            go;
  logic                            is_cam;
  logic                            single_unenc;
  logic                            commit_data;
  logic                            commit_dc;

  assign arst   = RST | GLOBAL_CLR | LOCAL_CLR;  // R2
  assign setup  = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign is_cam = ctrl.func == emb_pkg::FN_CAM;
  assign single_unenc = ctrl.unenc && ctrl.cmode == emb_pkg::CM_SINGLE;
  assign busy = (state != emb_pkg::ST_IDLE) | req_in.wr | req_in.fetch_strobe
              | req_q.wr | req_q.fetch_strobe;
  assign unmapped = !(PADDR inside {emb_pkg::OFF_CTRL, emb_pkg::OFF_ADDR, emb_pkg::OFF_WDATA,
                      emb_pkg::OFF_WMASK, emb_pkg::OFF_CMD, emb_pkg::OFF_KEY,
                      emb_pkg::OFF_STATUS, emb_pkg::OFF_RESULT});

  function automatic logic [emb_pkg::AW-1:0] lowest_index(
    input logic [emb_pkg::ENTRIES-1:0] v
  );
    logic [emb_pkg::AW-1:0] r;
    r = '0;
    for (int k = emb_pkg::ENTRIES - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = emb_pkg::AW'(k);
      end
    end
    return r;
  endfunction : lowest_index

  // APB slave: one wait-free answer, registered in the setup cycle
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & (unmapped | (PWRITE & (PADDR == emb_pkg::OFF_CMD) & busy));
      if (setup) begin
        case (PADDR)
          emb_pkg::OFF_CTRL:   PRDATA <= {18'h00000, ctrl};
          emb_pkg::OFF_ADDR:   PRDATA <= {27'h0000000, addr_reg};
          emb_pkg::OFF_WDATA:  PRDATA <= wdata;
          emb_pkg::OFF_WMASK:  PRDATA <= wmask;
          emb_pkg::OFF_KEY:    PRDATA <= key;
          emb_pkg::OFF_STATUS: PRDATA <= {22'h000000, busy, MATCH, 3'h0, index};
          emb_pkg::OFF_RESULT: PRDATA <= ctrl.regs[1] ? result_q : result;  // R18
          default:             PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-visible setup registers
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      ctrl     <= emb_pkg::CTRL_RESET;
      addr_reg <= '0;
      wdata    <= 32'h0000_0000;
      wmask    <= 32'h0000_0000;
      key      <= 32'h0000_0000;
    end else if (wr_acc) begin
      case (PADDR)
        emb_pkg::OFF_CTRL:  ctrl     <= PWDATA[13:0];
        emb_pkg::OFF_ADDR:  addr_reg <= PWDATA[emb_pkg::AW-1:0];
        emb_pkg::OFF_WDATA: wdata    <= PWDATA;
        emb_pkg::OFF_WMASK: wmask    <= PWDATA;
        emb_pkg::OFF_KEY:   key      <= PWDATA;
        default:            ;
      endcase
    end
  end

  // Request capture; strobes pulse, address and data hold
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      req_in <= '0;
      req_q  <= '0;
    end else begin
      req_in.wr           <= 1'b0;
      req_in.mask         <= 1'b0;
      req_in.fetch_strobe <= 1'b0;
      if (wr_acc && PADDR == emb_pkg::OFF_CMD) begin  // R23
        req_in.wr           <= PWDATA[emb_pkg::CMD_WRITE_BIT];
        req_in.mask         <= PWDATA[emb_pkg::CMD_MASK_BIT];
        req_in.fetch_strobe <= PWDATA[emb_pkg::CMD_READ_BIT] & ~PWDATA[emb_pkg::CMD_WRITE_BIT];
        req_in.waddr        <= addr_reg;
        req_in.raddr        <= addr_reg;
        req_in.data         <= PWDATA[emb_pkg::CMD_WRITE_BIT] ? wdata : key;  // R3
        req_in.dcm          <= wmask;
      end
      req_q <= req_in;
    end
  end

  // Each optional stage picked on its own
  always_comb begin
    req_eff              = req_in;  // R18
    req_eff.data         = ctrl.regs[0] ? req_q.data : req_in.data;
    req_eff.dcm          = ctrl.regs[0] ? req_q.dcm : req_in.dcm;
    req_eff.raddr        = ctrl.regs[2] ? req_q.raddr : req_in.raddr;
    req_eff.waddr        = ctrl.regs[3] ? req_q.waddr : req_in.waddr;
    req_eff.wr           = ctrl.regs[4] ? req_q.wr : req_in.wr;
    req_eff.mask         = ctrl.regs[4] ? req_q.mask : req_in.mask;
    req_eff.fetch_strobe = ctrl.regs[5] ? req_q.fetch_strobe : req_in.fetch_strobe;
  end

  // Off blocks and ROM writes are dropped; sequencing stays simple
  assign go = (ctrl.func != emb_pkg::FN_OFF)  // R22
            & (req_eff.fetch_strobe | (req_eff.wr & (ctrl.func != emb_pkg::FN_ROM)));  // R20

  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      state <= emb_pkg::ST_IDLE;
      op    <= '0;
    end else if (ctrl.clr) begin
      state <= emb_pkg::ST_IDLE;  // R2
    end else begin
      case (state)
        emb_pkg::ST_IDLE: begin
          if (go) begin
            op <= req_eff;
            if (ctrl.lowpwr) begin
              state <= emb_pkg::ST_SLOW;  // R21
            end else if (req_eff.wr) begin
              state <= emb_pkg::ST_WR1;
            end else begin
              state <= emb_pkg::ST_LOOK;
            end
          end
        end
        emb_pkg::ST_SLOW: state <= op.wr ? emb_pkg::ST_WR1 : emb_pkg::ST_LOOK;
        emb_pkg::ST_WR1:  state <= emb_pkg::ST_WR2;  // R12 R17
        emb_pkg::ST_WR2:  state <= (op.mask && is_cam) ? emb_pkg::ST_WR3 : emb_pkg::ST_IDLE;
        emb_pkg::ST_WR3:  state <= emb_pkg::ST_IDLE;  // R17
        emb_pkg::ST_LOOK: begin
          if (is_cam && ctrl.cmode == emb_pkg::CM_MULTI) begin
            state <= emb_pkg::ST_LOOK2;  // R14
          end else begin
            state <= emb_pkg::ST_IDLE;  // R12 R16
          end
        end
        emb_pkg::ST_LOOK2: state <= emb_pkg::ST_IDLE;
        default:           state <= emb_pkg::ST_IDLE;
      endcase
    end
  end

  // Internal write pulses; fabric never times a write enable itself
  assign commit_data = state == emb_pkg::ST_WR2;  // R24
  assign commit_dc   = state == emb_pkg::ST_WR3;
  // Bank select steals key bit 31 in unencoded single mode
  assign care = single_unenc ? emb_pkg::CARE_UNEN : emb_pkg::CARE_ALL;  // R10

  for (genvar i = 0; i < emb_pkg::ENTRIES; i++) begin : g_entry  // R5
    always_ff @(posedge CLK or posedge arst) begin
      if (arst) begin
        mem_data[i] <= INIT_IMAGE[i*emb_pkg::WIDTH +: emb_pkg::WIDTH];  // R17 R20
        mem_dc[i]   <= '0;
      end else if (commit_data && op.waddr == emb_pkg::AW'(i)) begin
        // Split halves share one width, capped at eight bits
        mem_data[i] <= ctrl.split ? {24'h000000, op.data[emb_pkg::SPLIT_W-1:0]} : op.data;  // R1
        mem_dc[i]   <= '0;
      end else if (commit_dc && op.waddr == emb_pkg::AW'(i)) begin
        mem_dc[i] <= op.dcm;  // R6
      end
    end
    // Fast mode gives up the upper half to fit one-cycle lines
    assign hit_vec[i] = (((mem_data[i] ^ op.data) & ~mem_dc[i] & care) == '0)  // R4 R6
                      && !(ctrl.cmode == emb_pkg::CM_FAST && i >= emb_pkg::LINES);  // R16
  end

  for (genvar j = 0; j < emb_pkg::LINES; j++) begin : g_bank
    assign bank_lines[j] = hit_vec[2*j + (op.data[emb_pkg::BANK_BIT] ? 1 : 0)];  // R11
  end

  assign scope_hit = single_unenc ? |bank_lines : |hit_vec;

  // Lookup and read results
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      MATCH    <= 1'b0;
      index    <= '0;
      result   <= 32'h0000_0000;
      result_q <= 32'h0000_0000;
    end else if (ctrl.clr) begin
      MATCH    <= 1'b0;  // R2
      index    <= '0;
      result   <= 32'h0000_0000;
      result_q <= 32'h0000_0000;
    end else begin
      result_q <= result;  // R19
      if (state == emb_pkg::ST_LOOK && is_cam) begin
        MATCH <= scope_hit;  // R4 R26
        index <= lowest_index(hit_vec);  // R3
        case (ctrl.cmode)  // R7
          emb_pkg::CM_SINGLE: begin
            if (ctrl.unenc) begin
              result <= {16'h0000, bank_lines};  // R9
            end else begin
              result <= {27'h0000000, lowest_index(hit_vec)};  // R8
            end
          end
          // Duplicates need all lines; encoding stays in the fabric
          emb_pkg::CM_MULTI: result <= {16'h0000, hit_vec[15:0]};  // R13 R14 R15
          emb_pkg::CM_FAST:  result <= {16'h0000, hit_vec[15:0]};  // R16
          default:           result <= 32'h0000_0000;
        endcase
      end else if (state == emb_pkg::ST_LOOK2) begin
        result <= {hit_vec[31:16], 16'h0000};  // R14
      end else if (state == emb_pkg::ST_LOOK) begin
        result <= ctrl.split ? {24'h000000, mem_data[op.raddr][emb_pkg::SPLIT_W-1:0]}
                             : mem_data[op.raddr];  // R1 R20
      end
    end
  end

  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      POWER_DOWN <= 1'b1;
    end else begin
      POWER_DOWN <= ctrl.func == emb_pkg::FN_OFF;  // R22
    end
  end

  // Checks
  logic [emb_pkg::ENTRIES-1:0] hit_q;
  always_ff @(posedge CLK or posedge arst) begin
    if (arst) begin
      hit_q <= '0;
    end else begin
      hit_q <= hit_vec;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (arst);

  write_two_cyc_a: assert property (  // R12
    (state == emb_pkg::ST_WR1 && !(op.mask && is_cam) && !ctrl.clr)
      |=> state == emb_pkg::ST_WR2 ##1 state == emb_pkg::ST_IDLE)
    else $error("plain write did not take two cycles");
  dc_write_len_a: assert property (  // R17
    (state == emb_pkg::ST_WR1 && op.mask && is_cam && !ctrl.clr)
      |=> state == emb_pkg::ST_WR2 ##1 state == emb_pkg::ST_WR3
          ##1 state == emb_pkg::ST_IDLE)
    else $error("masked write did not take three cycles");
  multi_two_a: assert property (  // R14
    (state == emb_pkg::ST_LOOK && is_cam && ctrl.cmode == emb_pkg::CM_MULTI && !ctrl.clr)
      |=> state == emb_pkg::ST_LOOK2 ##1 state == emb_pkg::ST_IDLE)
    else $error("multiple-match lookup not two cycles");
  hit_flag_a: assert property (  // R4
    (state == emb_pkg::ST_LOOK && is_cam && scope_hit && !ctrl.clr) |=> MATCH)
    else $error("match flag low despite hit");
  miss_flag_a: assert property (  // R26
    (state == emb_pkg::ST_LOOK && is_cam && !scope_hit) |=> !MATCH)
    else $error("match flag high on miss");
  enc_index_a: assert property (  // R8
    (state == emb_pkg::ST_LOOK && is_cam && ctrl.cmode == emb_pkg::CM_SINGLE
      && !ctrl.unenc && |hit_vec && !ctrl.clr && $stable(ctrl))
      |=> hit_q[index] && result[emb_pkg::AW-1:0] == index && $stable(ctrl))
    else $error("encoded index is not a hit");
  fast_scope_a: assert property (  // R16
    (ctrl.cmode == emb_pkg::CM_FAST) |-> hit_vec[31:16] == 16'h0000)
    else $error("fast mode reports upper entries");
  slow_wait_a: assert property (  // R21
    (state == emb_pkg::ST_IDLE && go && ctrl.lowpwr && !ctrl.clr)
      |=> state == emb_pkg::ST_SLOW ##1 state != emb_pkg::ST_IDLE)
    else $error("low power access skipped wait");
  off_idle_a: assert property (  // R22
    (POWER_DOWN && $past(POWER_DOWN) && state == emb_pkg::ST_IDLE) |=> state == emb_pkg::ST_IDLE)
    else $error("powered-down block started work");
  rom_ro_a: assert property (  // R20
    (state == emb_pkg::ST_IDLE && ctrl.func == emb_pkg::FN_ROM && !req_eff.fetch_strobe)
      |=> state == emb_pkg::ST_IDLE)
    else $error("ROM accepted a write");

  // Flag moves only on a lookup edge or a clear
  match_hold_a: assert property (  // R4
    (state != emb_pkg::ST_LOOK && !ctrl.clr) |=> $stable(MATCH))
    else $error("match flag changed without lookup");
  unenc_flag_a: assert property (  // R9
    (state == emb_pkg::ST_LOOK && is_cam && single_unenc && !ctrl.clr)
      |=> MATCH == (result[15:0] != 16'h0000))
    else $error("unencoded lines disagree with flag");
  split_word_a: assert property (  // R1
    (state == emb_pkg::ST_WR2 && ctrl.split && !ctrl.clr)
      |=> mem_data[op.waddr][31:8] == 24'h000000)
    else $error("split write wider than eight bits");
  power_off_a: assert property (  // R22
    (ctrl.func == emb_pkg::FN_OFF) |=> POWER_DOWN)
    else $error("unused block not powered down");

  dc_write_c:   cover property (state == emb_pkg::ST_WR3);
  multi_look_c: cover property (state == emb_pkg::ST_LOOK2 ##1 MATCH);
  fast_hit_c:   cover property (state == emb_pkg::ST_LOOK && ctrl.cmode == emb_pkg::CM_FAST
                                ##1 MATCH);
  unenc_hit_c:  cover property (state == emb_pkg::ST_LOOK && single_unenc ##1 MATCH);
endmodule : emb_memory_block
`default_nettype wire

// *** testbench/emb_fabric_model.sv ***
// Fabric logic model: APB master that reaches the memory block's registers.
// Assumes CLK from the bench; every call starts just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module emb_fabric_model (
  input  wire logic        CLK,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic [7:0]       PADDR,
  output logic [31:0]      PWDATA,
  input  wire logic        PREADY,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PSLVERR
);
  logic [31:0] rdata;
  logic        rerr;

  initial begin
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0000_0000;
  end

  // Held until PREADY is sampled; idle lines flip so stale data never matches
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK);
    while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr  = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    PADDR   <= ~a;
    PWDATA  <= ~d;
    @(posedge CLK);
  endtask : xfer
endmodule : emb_fabric_model
`default_nettype wire

// *** testbench/tb_emb_memory_block.sv ***
// Self-checking bench of the embedded memory block over APB.
// Assumes emb_pkg and emb_fabric_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_emb_memory_block;
  logic        clk;
  logic        rst;
  logic        gclr;
  logic        lclr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        match;
  logic        pdown;
  logic [31:0] v;
  int          errors;
  int          tests_run;

  function automatic logic [emb_pkg::ENTRIES*emb_pkg::WIDTH-1:0] img();
    logic [emb_pkg::ENTRIES*emb_pkg::WIDTH-1:0] m;
    for (int i = 0; i < 32; i++) begin
      m[32*i +: 32] = 32'hA5A5_0000 | 32'(i);
    end
    return m;
  endfunction : img

  emb_memory_block #(.INIT_IMAGE(img())) emb_memory_block_i (
    .CLK(clk), .RST(rst), .GLOBAL_CLR(gclr), .LOCAL_CLR(lclr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MATCH(match), .POWER_DOWN(pdown));

  emb_fabric_model emb_fabric_model_i (
    .CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    emb_fabric_model_i.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    emb_fabric_model_i.xfer(1'b0, a, 32'h0);
    d = emb_fabric_model_i.rdata;
  endtask : rd

  // Commands are refused while busy, so each cmd call waits for idle
  task automatic idle();
    do rd(emb_pkg::OFF_STATUS, v);
    while (v[emb_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask : idle

  task automatic cmd(input logic [31:0] c);
    wr(emb_pkg::OFF_CMD, c);
    idle();
  endtask : cmd

  function automatic logic [31:0] cw(logic [5:0] r, logic sp, logic lp, logic u,
                                     logic [1:0] m, logic [1:0] f);
    return {18'h0, r, 1'b0, sp, lp, u, m, f};
  endfunction : cw

  task automatic put(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    wr(emb_pkg::OFF_ADDR, {27'h0, a});
    wr(emb_pkg::OFF_WDATA, d);
    wr(emb_pkg::OFF_WMASK, m);
    cmd((m != 32'h0) ? 32'h5 : 32'h1);
  endtask : put

  task automatic get(input logic [4:0] a);
    wr(emb_pkg::OFF_ADDR, {27'h0, a});
    cmd(32'h2);
    rd(emb_pkg::OFF_RESULT, v);
  endtask : get

  task automatic look(input logic [31:0] k);
    wr(emb_pkg::OFF_KEY, k);
    cmd(32'h2);
    rd(emb_pkg::OFF_RESULT, v);
  endtask : look

  task automatic t_reset();
    chk1(pdown, 1'b1);
    chk1(match, 1'b0);
    rd(8'h20, v);
    chk32(v, 32'h0);
    chk1(emb_fabric_model_i.rerr, 1'b1);
  endtask : t_reset

  task automatic t_rom();
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, 2'h0, emb_pkg::FN_ROM));
    @(posedge clk);
    chk1(pdown, 1'b0);
    get(5'd7);
    chk32(v, 32'hA5A5_0007);
    put(5'd7, 32'h0, 32'h0);
    get(5'd7);
    chk32(v, 32'hA5A5_0007);
  endtask : t_rom

  // Pass 1 turns on every optional stage and reduced power
  task automatic t_ram();
    for (int i = 0; i < 2; i++) begin
      wr(emb_pkg::OFF_CTRL, cw(i ? 6'h3F : 6'h0, 1'b0, i[0], 1'b0, 2'h0, emb_pkg::FN_RAM));
      put(5'd9, 32'h1234_5678 + 32'(i), 32'h0);
      get(5'd9);
      chk32(v, 32'h1234_5678 + 32'(i));
    end
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b1, 1'b0, 1'b0, 2'h0, emb_pkg::FN_RAM));
    put(5'h01, 32'h3C, 32'h0);
    put(5'h11, 32'hC3, 32'h0);
    get(5'h01);
    chk32({24'h0, v[7:0]}, 32'h3C);
    get(5'h11);
    chk32({24'h0, v[7:0]}, 32'hC3);
  endtask : t_ram

  task automatic t_cam();
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, emb_pkg::CM_SINGLE, emb_pkg::FN_CAM));
    put(5'd12, 32'h0000_FA12, 32'h0);
    put(5'd13, 32'h0000_0F0F, 32'h0);
    look(32'h0000_FA12);
    chk32(v, 32'd12);
    chk1(match, 1'b1);
    look(32'h0000_FA13);
    chk1(match, 1'b0);
    put(5'd5, 32'h0BAD_0000, 32'h0000_00FF);
    look(32'h0BAD_0077);
    chk32(v, 32'd5);
    wr(emb_pkg::OFF_CMD, 32'h5);
    wr(emb_pkg::OFF_CMD, 32'h2);
    chk1(emb_fabric_model_i.rerr, 1'b1);
    idle();
  endtask : t_cam

  task automatic t_modes();
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b1, emb_pkg::CM_SINGLE, emb_pkg::FN_CAM));
    look(32'h0000_FA12);
    chk32({16'h0, v[15:0]}, 32'h0040);
    look(32'h8000_0F0F);
    chk32({16'h0, v[15:0]}, 32'h0040);
    look(32'h0000_0F0F);
    chk32({16'h0, v[15:0]}, 32'h0);
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, emb_pkg::CM_SINGLE, emb_pkg::FN_CAM));
    put(5'd3, 32'h0000_D0D0, 32'h0);
    put(5'd20, 32'h0000_D0D0, 32'h0);
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, emb_pkg::CM_MULTI, emb_pkg::FN_CAM));
    look(32'h0000_D0D0);
    chk32({16'h0, v[31:16]}, 32'h0010);
    rd(emb_pkg::OFF_STATUS, v);
    chk32({27'h0, v[4:0]}, 32'd3);
    wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, emb_pkg::CM_FAST, emb_pkg::FN_CAM));
    look(32'h0000_D0D0);
    chk32(v, 32'h0000_0008);
  endtask : t_modes

  task automatic t_clr();
    for (int i = 0; i < 2; i++) begin
      wr(emb_pkg::OFF_CTRL, cw(6'h0, 1'b0, 1'b0, 1'b0, emb_pkg::CM_SINGLE, emb_pkg::FN_CAM));
      put(5'd12, 32'h0000_FA12, 32'h0);
      look(32'h0000_FA12);
      chk1(match, 1'b1);
      gclr <= (i == 0);
      lclr <= (i == 1);
      repeat (2) @(posedge clk);
      gclr <= 1'b0;
      lclr <= 1'b0;
      @(posedge clk);
      chk1(match, 1'b0);
      chk1(pdown, 1'b1);
      rd(emb_pkg::OFF_CTRL, v);
      chk32(v, 32'h0);
    end
  endtask : t_clr

  initial begin
    rst = 1'b1;
    gclr = 1'b0;
    lclr = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rom();
    t_ram();
    t_cam();
    t_modes();
    t_clr();
    summarize();
  end

  // Whole run needs several hundred cycles; a hang stops well past that
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : tb_emb_memory_block
`default_nettype wire
